/* dcfg_pkg.sv */
// How it works
// - Bit 7 is spare storage only.
// - Plain read allowed; burst releases after next.
// - Plain reads become line reads; release at line.
// - Slow bit doubles external SCB RAM cycle.
// - Check SCB parity when enabled and RAM present.
// - Force bit makes generators produce even parity.
// - Every stored byte gets generated parity.
// - Every read byte checked, error flagged.
// - Dual address only when enabled and page nonzero.
// - Polarity bit sets termination output level.
// - Polarity cleared by pin reset only.
// - Enable bit selects differential drive mode.
// - Single-user mode strapped at reset; drive port.
// - RAM-present mode strapped at reset.
// - Voltage sense reported and steers pin cells.
// - Shared read data captured once pause acknowledged.
// - Soft reset clears device space only.
// - Unused bits zero; undefined config reads return zero.
// - Identity registers readable without pausing.
// - Shared access stretched until pause acknowledged.
// - No device response when both spaces disabled.
// - Option register cleared only by pin reset.
package dcfg_pkg;

	// ***************************************************
	// Register map
	// ***************************************************
	localparam logic [7:0] DEVICE_OPTION_REG_OFS = 8'h40;
	localparam logic [7:0] STRAP_STATUS_REG_OFS  = 8'h41;
	localparam logic [7:0] VENDOR_CODE_REG_OFS   = 8'h80;
	localparam logic [7:0] PRODUCT_CODE_REG_OFS  = 8'h82;
	localparam logic [7:0] ZERO_READ_OFS         = 8'h8F;
	localparam logic [7:0] OPTION_RESET          = 8'h00;
	localparam logic [4:0] STATUS_UNUSED         = 5'h00;

	// ***************************************************
	// PCI memory read command codes
	// ***************************************************
	localparam logic [3:0] CMD_MEM_READ      = 4'h6;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;

	// ***************************************************
	// SCB RAM cycle lengths in clocks
	// ***************************************************
	localparam logic [1:0] SCB_CYCLE_NORMAL = 2'h1;
	localparam logic [1:0] SCB_CYCLE_SLOW   = 2'h2;

	typedef struct packed {
		logic spare_config_bit;
		logic plain_read_cmd_enable;
		logic slow_scb_ram_cycle;
		logic ext_scb_parity_check_enable;
		logic force_even_parity;
		logic dual_addr_cycle_enable;
		logic term_power_polarity;
		logic diff_active_negation_enable;
	} dcfg_option_t;

	typedef struct packed {
		logic mem_port_single_user;
		logic ext_ram_present;
		logic bus_voltage_sense;
	} dcfg_strap_t;

	typedef struct packed {
		logic       req;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcfg_access_t;

	typedef enum logic [1:0] {
		DCFG_IDLE  = 2'b00,
		DCFG_PAUSE = 2'b01,
		DCFG_DONE  = 2'b11
	} dcfg_state_t;

endpackage

/* dcfg_top.sv */
`timescale 1ns/100ps
module dcfg_top #(
	parameter logic [15:0] VENDOR_CODE  = 16'h1234,
	parameter logic [15:0] PRODUCT_CODE = 16'h5678
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  soft_chip_reset,
	input  wire dcfg_pkg::dcfg_access_t cfg_acc,
	output logic                       cfg_ack,
	output logic [7:0]                 cfg_rdata,
	input  wire dcfg_pkg::dcfg_access_t dev_acc,
	output logic                       dev_ack,
	output logic [7:0]                 dev_rdata,
	input  wire logic                  io_space_enable,
	input  wire logic                  mem_space_enable,
	input  wire logic                  pause_acknowledge,
	output logic                       auto_access_pause,
	input  wire logic [7:0]            internal_reg_data_bus,
	output logic                       shared_wr,
	output logic [7:0]                 shared_addr,
	output logic [7:0]                 shared_wdata,
	input  wire logic                  ext_arb_ack_n_in,
	input  wire logic                  ram_present_strap_n_in,
	input  wire logic                  bus_voltage_in,
	output dcfg_pkg::dcfg_strap_t      strap_status,
	input  wire logic [3:0]            master_cmd_in,
	output logic [3:0]                 master_cmd_out,
	input  wire logic                  lat_timer_expired,
	input  wire logic                  gnt_active,
	output logic                       release_after_next,
	output logic                       release_at_line_end,
	output logic [1:0]                 scb_cycle_clocks,
	output logic                       scb_parity_check_active,
	input  wire logic [7:0]            par_gen_data,
	output logic                       par_gen_bit,
	input  wire logic                  par_chk_valid,
	input  wire logic [7:0]            par_chk_data,
	input  wire logic                  par_chk_bit,
	output logic                       parity_error,
	input  wire logic [31:0]           upper_host_address,
	output logic                       dual_addr_cycle_active,
	input  wire logic                  term_power_request,
	output logic                       term_power_control_out,
	output logic                       diff_active_negation_enable,
	output logic                       mem_port_drive_all,
	output logic                       pin_cell_5v_mode,
	output logic                       spare_config_bit
);

	// ***************************************************
	// Helper functions
	// ***************************************************
	function automatic logic odd_par(input logic [7:0] d);
		odd_par = ~(^d);
	endfunction

	function automatic logic pci_only(input logic [7:0] a);
		pci_only = (a[7:2] == dcfg_pkg::VENDOR_CODE_REG_OFS[7:2]);
	endfunction

	// ***************************************************
	// Strap synchronisers and capture
	// ***************************************************
	logic [2:0]            strap_s1_reg;
	logic [2:0]            strap_s2_reg;
	logic                  pack_s1_reg;
	logic                  pack_s2_reg;
	dcfg_pkg::dcfg_strap_t strap_reg;
	dcfg_pkg::dcfg_strap_t strap_next;

	always_ff @(posedge ref_clk) begin
		strap_s1_reg <= {~ext_arb_ack_n_in, ~ram_present_strap_n_in, bus_voltage_in};
		strap_s2_reg <= strap_s1_reg;
		pack_s1_reg  <= pause_acknowledge;
		pack_s2_reg  <= pack_s1_reg;
	end

	// Straps track the pins while reset is held and freeze at release.
	always_comb begin
		strap_next = strap_reg;
		if (!rst_n) begin
			strap_next = dcfg_pkg::dcfg_strap_t'(strap_s2_reg);
		end
	end

	always_ff @(posedge ref_clk) begin
		strap_reg <= strap_next;
	end

	// ***************************************************
	// Configuration space option register
	// ***************************************************
	dcfg_pkg::dcfg_option_t opt_reg;
	dcfg_pkg::dcfg_option_t opt_next;
	logic                   cfg_ack_reg;
	logic                   cfg_ack_next;
	logic [7:0]             cfg_rdata_reg;
	logic [7:0]             cfg_rdata_next;

	always_comb begin
		opt_next       = opt_reg;
		cfg_ack_next   = cfg_acc.req & ~cfg_ack_reg;
		cfg_rdata_next = cfg_rdata_reg;
		if (cfg_acc.req && !cfg_ack_reg) begin
			cfg_rdata_next = 8'h00;
			if (cfg_acc.addr == dcfg_pkg::DEVICE_OPTION_REG_OFS) begin
				cfg_rdata_next = opt_reg;
				if (cfg_acc.we) begin
					opt_next = dcfg_pkg::dcfg_option_t'(cfg_acc.wdata);
				end
			end else if (cfg_acc.addr == dcfg_pkg::STRAP_STATUS_REG_OFS) begin
				cfg_rdata_next = {dcfg_pkg::STATUS_UNUSED, strap_reg};
			end
		end
		// Soft chip reset is deliberately not looked at here.
		if (!rst_n) begin
			opt_next       = dcfg_pkg::dcfg_option_t'(dcfg_pkg::OPTION_RESET);
			cfg_ack_next   = 1'b0;
			cfg_rdata_next = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		opt_reg       <= opt_next;
		cfg_ack_reg   <= cfg_ack_next;
		cfg_rdata_reg <= cfg_rdata_next;
	end

	// ***************************************************
	// Device space access with pause stretching
	// ***************************************************
	dcfg_pkg::dcfg_state_t st_reg;
	dcfg_pkg::dcfg_state_t st_next;
	logic                  dack_reg;
	logic                  dack_next;
	logic [7:0]            drd_reg;
	logic [7:0]            drd_next;
	logic                  aap_reg;
	logic                  aap_next;
	logic                  swr_reg;
	logic                  swr_next;
	logic [7:0]            sadr_reg;
	logic [7:0]            sadr_next;
	logic [7:0]            swd_reg;
	logic [7:0]            swd_next;
	logic                  space_on;
	logic                  dev_rst;

	assign space_on = io_space_enable | mem_space_enable;
	assign dev_rst  = !rst_n || soft_chip_reset;

	always_comb begin
		st_next   = st_reg;
		dack_next = 1'b0;
		drd_next  = drd_reg;
		aap_next  = aap_reg;
		swr_next  = 1'b0;
		sadr_next = sadr_reg;
		swd_next  = swd_reg;
		unique case (st_reg)
			dcfg_pkg::DCFG_IDLE: begin
				if (dev_acc.req && space_on) begin
					if (pci_only(dev_acc.addr)) begin
						unique case (dev_acc.addr[1:0])
							2'h0: drd_next = VENDOR_CODE[7:0];
							2'h1: drd_next = VENDOR_CODE[15:8];
							2'h2: drd_next = PRODUCT_CODE[7:0];
							2'h3: drd_next = PRODUCT_CODE[15:8];
						endcase
						dack_next = 1'b1;
						st_next   = dcfg_pkg::DCFG_DONE;
					end else if (dev_acc.addr == dcfg_pkg::ZERO_READ_OFS) begin
						drd_next  = 8'h00;
						dack_next = 1'b1;
						st_next   = dcfg_pkg::DCFG_DONE;
					end else begin
						aap_next = ~pack_s2_reg;
						st_next  = dcfg_pkg::DCFG_PAUSE;
					end
				end
			end
			dcfg_pkg::DCFG_PAUSE: begin
				if (!dev_acc.req || !space_on) begin
					aap_next = 1'b0;
					st_next  = dcfg_pkg::DCFG_IDLE;
				end else if (pack_s2_reg) begin
					drd_next  = internal_reg_data_bus;
					swr_next  = dev_acc.we;
					sadr_next = dev_acc.addr;
					swd_next  = dev_acc.wdata;
					dack_next = 1'b1;
					aap_next  = 1'b0;
					st_next   = dcfg_pkg::DCFG_DONE;
				end else begin
					// A stale synchronised acknowledge may have skipped the request, so raise it now.
					aap_next = 1'b1;
				end
			end
			dcfg_pkg::DCFG_DONE: begin
				if (!dev_acc.req) begin
					st_next = dcfg_pkg::DCFG_IDLE;
				end
			end
			default: begin
				st_next = dcfg_pkg::DCFG_IDLE;
			end
		endcase
		if (dev_rst) begin
			st_next   = dcfg_pkg::DCFG_IDLE;
			dack_next = 1'b0;
			drd_next  = 8'h00;
			aap_next  = 1'b0;
			swr_next  = 1'b0;
			sadr_next = 8'h00;
			swd_next  = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg   <= st_next;
		dack_reg <= dack_next;
		drd_reg  <= drd_next;
		aap_reg  <= aap_next;
		swr_reg  <= swr_next;
		sadr_reg <= sadr_next;
		swd_reg  <= swd_next;
	end

	// ***************************************************
	// Datapath controls steered by the option register
	// ***************************************************
	logic [3:0] cmd_next;
	logic       ran_next;
	logic       rle_next;
	logic [1:0] cyc_next;
	logic       spc_next;
	logic       pg_next;
	logic       pe_next;
	logic       dac_next;
	logic       tp_next;
	logic [3:0] cmd_reg;
	logic       ran_reg;
	logic       rle_reg;
	logic [1:0] cyc_reg;
	logic       spc_reg;
	logic       pg_reg;
	logic       pe_reg;
	logic       dac_reg;
	logic       tp_reg;
	logic       lat_drop;

	assign lat_drop = lat_timer_expired & ~gnt_active;

	always_comb begin
		cmd_next = master_cmd_in;
		if (!opt_reg.plain_read_cmd_enable && master_cmd_in == dcfg_pkg::CMD_MEM_READ) begin
			cmd_next = dcfg_pkg::CMD_MEM_READ_LINE;
		end
		ran_next = lat_drop & opt_reg.plain_read_cmd_enable;
		rle_next = lat_drop & ~opt_reg.plain_read_cmd_enable;
		cyc_next = opt_reg.slow_scb_ram_cycle ? dcfg_pkg::SCB_CYCLE_SLOW
			: dcfg_pkg::SCB_CYCLE_NORMAL;
		spc_next = opt_reg.ext_scb_parity_check_enable & strap_reg.ext_ram_present;
		pg_next  = odd_par(par_gen_data) ^ opt_reg.force_even_parity;
		pe_next  = par_chk_valid & (odd_par(par_chk_data) != par_chk_bit);
		dac_next = opt_reg.dual_addr_cycle_enable & (|upper_host_address);
		tp_next  = term_power_request ^ opt_reg.term_power_polarity;
		if (!rst_n) begin
			cmd_next = 4'h0;
			ran_next = 1'b0;
			rle_next = 1'b0;
			cyc_next = dcfg_pkg::SCB_CYCLE_NORMAL;
			spc_next = 1'b0;
			pg_next  = 1'b0;
			pe_next  = 1'b0;
			dac_next = 1'b0;
			tp_next  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		cmd_reg <= cmd_next;
		ran_reg <= ran_next;
		rle_reg <= rle_next;
		cyc_reg <= cyc_next;
		spc_reg <= spc_next;
		pg_reg  <= pg_next;
		pe_reg  <= pe_next;
		dac_reg <= dac_next;
		tp_reg  <= tp_next;
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign cfg_ack                     = cfg_ack_reg;
	assign cfg_rdata                   = cfg_rdata_reg;
	assign dev_ack                     = dack_reg;
	assign dev_rdata                   = drd_reg;
	assign auto_access_pause           = aap_reg;
	assign shared_wr                   = swr_reg;
	assign shared_addr                 = sadr_reg;
	assign shared_wdata                = swd_reg;
	assign strap_status                = strap_reg;
	assign master_cmd_out              = cmd_reg;
	assign release_after_next          = ran_reg;
	assign release_at_line_end         = rle_reg;
	assign scb_cycle_clocks            = cyc_reg;
	assign scb_parity_check_active     = spc_reg;
	assign par_gen_bit                 = pg_reg;
	assign parity_error                = pe_reg;
	assign dual_addr_cycle_active      = dac_reg;
	assign term_power_control_out      = tp_reg;
	assign diff_active_negation_enable = opt_reg.diff_active_negation_enable;
	assign mem_port_drive_all          = strap_reg.mem_port_single_user;
	assign pin_cell_5v_mode            = strap_reg.bus_voltage_sense;
	assign spare_config_bit            = opt_reg.spare_config_bit;

endmodule

/* dcfg_assertions.sv */
`timescale 1ns/100ps
module dcfg_assertions (
	input wire logic			ref_clk,
	input wire logic			rst_n,
	input wire logic			soft_chip_reset,
	input wire dcfg_pkg::dcfg_access_t	cfg_acc,
	input wire logic			cfg_ack,
	input wire dcfg_pkg::dcfg_access_t	dev_acc,
	input wire logic			dev_ack,
	input wire logic [7:0]			dev_rdata,
	input wire logic			io_space_enable,
	input wire logic			mem_space_enable,
	input wire logic			pause_acknowledge,
	input wire logic			auto_access_pause,
	input wire logic [7:0]			internal_reg_data_bus,
	input wire logic			shared_wr,
	input wire logic [7:0]			shared_wdata,
	input wire dcfg_pkg::dcfg_strap_t	strap_status,
	input wire logic			par_chk_valid,
	input wire logic [7:0]			par_chk_data,
	input wire logic			par_chk_bit,
	input wire logic			parity_error,
	input wire logic [31:0]			upper_host_address,
	input wire logic			dual_addr_cycle_active
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic id_addr;
	logic any_space;
	assign id_addr = dev_acc.addr[7:2] == 6'h20 || dev_acc.addr == 8'h8F;
	assign any_space = io_space_enable || mem_space_enable;
	sequence s_id_req;
		dev_acc.req && !dev_ack && !auto_access_pause && any_space && id_addr;
	endsequence
	sequence s_shared_ack;
		dev_ack && !id_addr;
	endsequence
	a_cfg_answer: assert property (cfg_acc.req && !cfg_ack |=> cfg_ack)
		else $error("config access not answered in one cycle");
	a_id_answer: assert property (s_id_req |=> dev_ack)
		else $error("identity access not answered in one cycle");
	a_no_space: assert property (dev_acc.req && !any_space && !dev_ack && !auto_access_pause
		|=> !dev_ack)
		else $error("device access answered with both spaces off");
	a_shared_wait: assert property (s_shared_ack |-> $past(pause_acknowledge, 2))
		else $error("shared access answered before pause");
	a_pause_hold: assert property (auto_access_pause && !soft_chip_reset
		|=> auto_access_pause || dev_ack)
		else $error("pause request dropped before answer");
	a_read_capture: assert property (s_shared_ack and !dev_acc.we
		|-> dev_rdata == $past(internal_reg_data_bus))
		else $error("shared read data not captured from bus");
	a_write_pass: assert property (shared_wr
		|-> dev_ack && dev_acc.we && shared_wdata == dev_acc.wdata)
		else $error("shared write mismatch");
	a_parity_flag: assert property (par_chk_valid && !(^{par_chk_data, par_chk_bit})
		|=> parity_error)
		else $error("bad parity not flagged");
	a_parity_quiet: assert property (!par_chk_valid |=> !parity_error)
		else $error("parity error without check");
	a_strap_hold: assert property ($past(rst_n) |-> $stable(strap_status))
		else $error("strap status changed outside reset");
	a_dual_gate: assert property (dual_addr_cycle_active
		|-> $past(upper_host_address) != 32'h0)
		else $error("dual address with zero page");
endmodule
bind dcfg_top dcfg_assertions dcfg_assertions_inst (.*);

/* dcfg_seq_model.sv */
`timescale 1ns/100ps
module dcfg_seq_model (
	input wire logic	ref_clk,
	input wire logic	rst_n,
	input wire logic	slow,
	input wire logic	auto_access_pause,
	input wire logic	shared_wr,
	input wire logic [7:0]	shared_wdata,
	output logic		pause_acknowledge,
	output logic [7:0]	internal_reg_data_bus
);
	// ****************************************
	// Sequencer stand-in
	// ****************************************
	logic [3:0] wait_reg;
	logic [7:0] store_reg;
	logic [7:0] noise_reg;
	// The bus changes every cycle unless the sequencer is paused.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_reg <= 4'h0;
			store_reg <= 8'h00;
			noise_reg <= 8'h5A;
			pause_acknowledge <= 1'b0;
		end else begin
			noise_reg <= noise_reg + 8'h3B;
			if (!auto_access_pause) begin
				wait_reg <= 4'h0;
				pause_acknowledge <= 1'b0;
			end else if (wait_reg == (slow ? 4'h9 : 4'h1)) begin
				pause_acknowledge <= 1'b1;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
			if (shared_wr) begin
				store_reg <= shared_wdata;
			end
		end
	end
	assign internal_reg_data_bus = pause_acknowledge ? store_reg : noise_reg;
endmodule

/* tb.sv */
`timescale 1ns/100ps
module tb;
	localparam logic [15:0] VC = 16'h2468; // Arbitrary value.
	localparam logic [15:0] PC = 16'h1357; // Arbitrary value.
	logic	ref_clk, rst_n, soft_chip_reset, io_space_enable, mem_space_enable, slow;
	logic	pause_acknowledge, auto_access_pause, shared_wr, cfg_ack, dev_ack;
	logic	ext_arb_ack_n_in, ram_present_strap_n_in, bus_voltage_in, lat_timer_expired;
	logic	gnt_active, release_after_next, release_at_line_end, scb_parity_check_active;
	logic	par_gen_bit, par_chk_valid, par_chk_bit, parity_error, dual_addr_cycle_active;
	logic	term_power_request, term_power_control_out, diff_active_negation_enable;
	logic	mem_port_drive_all, pin_cell_5v_mode, spare_config_bit;
	logic [1:0]	scb_cycle_clocks;
	logic [3:0]	master_cmd_in, master_cmd_out;
	logic [7:0]	cfg_rdata, dev_rdata, internal_reg_data_bus, shared_addr, shared_wdata;
	logic [7:0]	par_gen_data, par_chk_data, rd, opt;
	logic [31:0]	upper_host_address;
	int		fails, samples_checked, i;
	dcfg_pkg::dcfg_access_t	cfg_acc, dev_acc;
	dcfg_pkg::dcfg_strap_t	strap_status;
	dcfg_top #(.VENDOR_CODE(VC), .PRODUCT_CODE(PC)) dcfg_top_inst (.*);
	dcfg_seq_model dcfg_seq_model_inst (.*);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic acc(input logic dv, input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge ref_clk);
		#1;
		if (dv) dev_acc = '{1'b1, we, a, d};
		else cfg_acc = '{1'b1, we, a, d};
		for (n = 0; n < 60; n++) begin
			@(posedge ref_clk);
			if ((dv ? dev_ack : cfg_ack) === 1'b1) break;
		end
		if (n == 60) begin
			fails++;
			print_verdict();
		end else begin
			rd = dv ? dev_rdata : cfg_rdata;
			#1;
			dev_acc.req = 1'b0;
			cfg_acc.req = 1'b0;
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic do_reset(input logic a, input logic r, input logic v);
		rst_n = 1'b0;
		ext_arb_ack_n_in = a;
		ram_present_strap_n_in = r;
		bus_voltage_in = v;
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		fails = 0;
		samples_checked = 0;
		soft_chip_reset = 1'b0;
		slow = 1'b0;
		cfg_acc = '0;
		dev_acc = '0;
		io_space_enable = 1'b1;
		mem_space_enable = 1'b0;
		master_cmd_in = dcfg_pkg::CMD_MEM_READ;
		lat_timer_expired = 1'b1;
		gnt_active = 1'b0;
		par_gen_data = 8'h01;
		par_chk_valid = 1'b0;
		par_chk_data = 8'h01;
		par_chk_bit = 1'b1;
		upper_host_address = 32'h1;
		term_power_request = 1'b1;
		do_reset(1'b0, 1'b1, 1'b1);
		acc(0, 0, 8'h40, 8'h00);
		check(rd, 8'h00);
		acc(0, 0, 8'h41, 8'h00);
		check(rd, 8'h05);
		check({strap_status, mem_port_drive_all, pin_cell_5v_mode}, 5'h17);
		for (i = 0; i < 9; i++) begin
			opt = (i == 8) ? 8'h00 : 8'h01 << i;
			acc(0, 1, 8'h40, opt);
			settle();
			check({master_cmd_out, release_after_next, release_at_line_end, scb_cycle_clocks,
				scb_parity_check_active, par_gen_bit, dual_addr_cycle_active,
				term_power_control_out, diff_active_negation_enable, spare_config_bit},
				{opt[6] ? 4'h6 : 4'hE, opt[6], !opt[6], opt[5] ? 2'h2 : 2'h1, 1'b0,
				opt[3], opt[2], !opt[1], opt[0], opt[7]});
			acc(0, 0, 8'h40, 8'h00);
			check(rd, opt);
		end
		acc(0, 1, 8'h40, 8'h06);
		upper_host_address = 32'h0;
		settle();
		check({dual_addr_cycle_active, term_power_control_out}, 2'h0);
		soft_chip_reset = 1'b1;
		settle();
		soft_chip_reset = 1'b0;
		acc(0, 0, 8'h40, 8'h00);
		check(rd, 8'h06);
		par_chk_valid = 1'b1;
		settle();
		check(parity_error, 1'b1);
		par_chk_bit = 1'b0;
		settle();
		check(parity_error, 1'b0);
		par_chk_valid = 1'b0;
		for (i = 0; i < 4; i++) begin
			acc(1, 0, 8'h80 + i[7:0], 8'h00);
			check(rd, ((i[1] ? PC : VC) >> (8 * i[0])) & 16'h00FF);
		end
		acc(1, 1, 8'h80, 8'hFF);
		acc(1, 0, 8'h80, 8'h00);
		check(rd, VC[7:0]);
		acc(1, 0, 8'h8F, 8'h00);
		check(rd, 8'h00);
		acc(1, 1, 8'h10, 8'hC3);
		check({shared_addr, shared_wdata}, 16'h10C3);
		slow = 1'b1;
		acc(1, 0, 8'h10, 8'h00);
		check(rd, 8'hC3);
		acc(1, 0, 8'h33, 8'h00);
		check(rd, 8'hC3);
		soft_chip_reset = 1'b1;
		settle();
		soft_chip_reset = 1'b0;
		check({dev_rdata, shared_addr, shared_wdata, auto_access_pause}, 25'h0);
		io_space_enable = 1'b0;
		dev_acc = '{1'b1, 1'b0, 8'h80, 8'h00};
		repeat (20) begin
			@(posedge ref_clk);
			#1;
			check(dev_ack, 1'b0);
		end
		dev_acc.req = 1'b0;
		mem_space_enable = 1'b1;
		acc(1, 0, 8'h81, 8'h00);
		check(rd, VC[15:8]);
		do_reset(1'b1, 1'b0, 1'b0);
		acc(0, 0, 8'h41, 8'h00);
		check(rd, 8'h02);
		acc(0, 0, 8'h40, 8'h00);
		check(rd, 8'h00);
		acc(0, 1, 8'h40, 8'h10);
		ext_arb_ack_n_in = 1'b0;
		ram_present_strap_n_in = 1'b1;
		settle();
		settle();
		check({strap_status, scb_parity_check_active}, 4'h5);
		print_verdict();
	end
endmodule
